// ==== hw/ddr_lp_pkg.sv ====
`default_nettype none
package ddr_lp_pkg;
  // ==========================================================
  // Clock and timer widths
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TMR_W = 10;

  function automatic int cyc_ceil(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  function automatic int cyc_floor(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_floor

  // ==========================================================
  // Times as printed or as plain defaults, in picoseconds
  localparam int T_REFI_PS = 7812500;
  localparam int T_REFI_HOT_PS = 3900000;
  localparam int T_ROW_PRE_PS = 15000;
  localparam int T_ALL_PRE_PS = 17500;
  localparam int T_REFRESH_CYCLE_PS = 127500;
  localparam int T_SR_EXIT_NONREAD_PS = 137500;
  localparam int T_WRITE_TO_READ_PS = 7500;
  localparam int T_WRITE_RECOVERY_PS = 15000;
  localparam int T_ROW_TO_COL_PS = 15000;

  // ==========================================================
  // Cycle counts
  localparam int WTR_MIN_CYC = 2;
  localparam int WTR_CYC = (cyc_ceil(T_WRITE_TO_READ_PS) > WTR_MIN_CYC)
    ? cyc_ceil(T_WRITE_TO_READ_PS) : WTR_MIN_CYC;
  localparam int CAS_LAT = 4;
  localparam int BURST_LEN = 4;
  localparam int RD_DONE_I = CAS_LAT + BURST_LEN / 2 + 1;
  localparam int WR_BASE_I = CAS_LAT - 1 + BURST_LEN / 2 + 1;
  localparam int WR_TAIL_I = (cyc_ceil(T_WRITE_RECOVERY_PS) > WTR_CYC)
    ? cyc_ceil(T_WRITE_RECOVERY_PS) : WTR_CYC;
  localparam logic [TMR_W-1:0] REFI_CYC = TMR_W'(cyc_floor(T_REFI_PS));
  localparam logic [TMR_W-1:0] REFI_HOT_CYC =
    TMR_W'(cyc_floor(T_REFI_HOT_PS));
  localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(cyc_ceil(T_ROW_PRE_PS));
  localparam logic [TMR_W-1:0] RPA_CYC = TMR_W'(cyc_ceil(T_ALL_PRE_PS));
  localparam logic [TMR_W-1:0] RFC_CYC =
    TMR_W'(cyc_ceil(T_REFRESH_CYCLE_PS));
  localparam logic [TMR_W-1:0] XSNR_CYC =
    TMR_W'(cyc_ceil(T_SR_EXIT_NONREAD_PS));
  localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(cyc_ceil(T_ROW_TO_COL_PS));
  localparam logic [TMR_W-1:0] XSRD_CYC = 10'h0C8;
  localparam logic [TMR_W-1:0] CKE_HOLD_CYC = 10'h003;
  localparam logic [TMR_W-1:0] XP_CYC = 10'h002;
  localparam logic [TMR_W-1:0] XARD_CYC = 10'h002;
  localparam logic [TMR_W-1:0] XARDS_CYC = 10'h007;
  localparam logic [TMR_W-1:0] ODT_OFF_CYC = 10'h003;
  localparam logic [TMR_W-1:0] RD_DONE_CYC = TMR_W'(RD_DONE_I);
  localparam logic [TMR_W-1:0] WR_DONE_CYC = TMR_W'(WR_BASE_I + WR_TAIL_I);

  // ==========================================================
  // Pin command codes on ras_n, cas_n, we_n (chip select low)
  localparam logic [2:0] PIN_NOP = 3'h7;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_RD = 3'h5;
  localparam logic [2:0] PIN_WR = 3'h4;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_REF = 3'h1;
  localparam int ADDR_BIT_TEN = 10;

  typedef enum logic [3:0] {
    UC_ACT = 4'h1,
    UC_RD = 4'h2,
    UC_WR = 4'h3,
    UC_PRE = 4'h4,
    UC_PREA = 4'h5,
    UC_SR_IN = 4'h6,
    UC_SR_OUT = 4'h7,
    UC_PD_IN = 4'h8,
    UC_PD_OUT = 4'h9
  } user_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_REF_PRE = 6'h04,
    ST_ODT_OFF = 6'h08,
    ST_SR = 6'h10,
    ST_PD = 6'h20
  } state_t;
endpackage : ddr_lp_pkg
`default_nettype wire

// ==== hw/timer_if.sv ====
`default_nettype none
interface timer_if #(parameter int W = 10);
  logic load;
  logic [W-1:0] value;
  logic idle;
  modport ctrl (output load, output value, input idle);
  modport tmr (input load, input value, output idle);
endinterface : timer_if
`default_nettype wire

// ==== hw/wait_timer.sv ====
`default_nettype none
module wait_timer #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic reset,
  timer_if.tmr t
);
  if (W < 2) begin : g_bad_width
    $error("wait_timer width too small");
  end

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  always_comb begin
    if (t.load) begin
      nxt_count = t.value;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - W'(1);
    end else begin
      nxt_count = count_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign t.idle = (count_ff == '0);
endmodule : wait_timer
`default_nettype wire

// ==== hw/ddr_lp_ctrl.sv ====
`default_nettype none
module ddr_lp_ctrl #(
  parameter int BANKS = 8,
  parameter int BANK_W = 3,
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire ddr_lp_pkg::user_cmd_t cmd_op,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic slow_exit_sel,
  input wire logic odt_request,
  input wire logic dll_reset_done,
  input wire logic hot_temp_pin,
  input wire logic dll_locked_pin,
  output logic cmd_ready,
  output logic cmd_err,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BANK_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic termination_control,
  output logic dll_reset_req,
  output logic in_self_refresh,
  output logic in_power_down
);
  import ddr_lp_pkg::*;

  if (BANKS != (1 << BANK_W) || ADDR_W <= ADDR_BIT_TEN) begin : g_bad
    $error("ddr_lp_ctrl bank or address width unsupported");
  end

  // ==========================================================
  // Timers: row/refresh waits, read lockout, clock enable hold
  timer_if #(.W(TMR_W)) m_if ();
  timer_if #(.W(TMR_W)) l_if ();
  timer_if #(.W(TMR_W)) h_if ();

  wait_timer #(.W(TMR_W)) u_main (.clk(clk), .reset(reset), .t(m_if));
  wait_timer #(.W(TMR_W)) u_lock (.clk(clk), .reset(reset), .t(l_if));
  wait_timer #(.W(TMR_W)) u_hold (.clk(clk), .reset(reset), .t(h_if));

  // ==========================================================
  // Pin synchronisers
  logic [1:0] hot_sync_ff;
  logic [1:0] dll_sync_ff;
  logic hot_temp;
  logic dll_locked;

  always_ff @(posedge clk) begin
    if (reset) begin
      hot_sync_ff <= 2'h0;
      dll_sync_ff <= 2'h0;
    end else begin
      hot_sync_ff <= {hot_sync_ff[0], hot_temp_pin};
      dll_sync_ff <= {dll_sync_ff[0], dll_locked_pin};
    end
  end
  assign hot_temp = hot_sync_ff[1];
  assign dll_locked = dll_sync_ff[1];

  // ==========================================================
  // State
  state_t state_ff, nxt_state;
  logic [BANKS-1:0] open_ff, nxt_open;
  logic [TMR_W-1:0] refi_ff, nxt_refi;
  logic cke_ff, nxt_cke;
  logic cs_n_ff, nxt_cs_n;
  logic [2:0] rcw_ff, nxt_rcw;
  logic [BANK_W-1:0] ba_ff, nxt_ba;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic odt_ff, nxt_odt;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;
  logic pd_act_ff, nxt_pd_act;
  logic dll_bad_ff, nxt_dll_bad;
  logic dll_req_ff, nxt_dll_req;
  logic m_ld, l_ld, h_ld, rearm, acc, ref_due, acted, ap;
  logic [TMR_W-1:0] m_val, l_val;

  assign acc = cmd_valid & ready_ff;
  assign ref_due = (refi_ff == '0);
  assign ap = cmd_addr[ADDR_BIT_TEN];

  always_comb begin
    nxt_state = state_ff;
    nxt_open = open_ff;
    nxt_cke = cke_ff;
    nxt_cs_n = 1'b0;
    nxt_rcw = PIN_NOP;
    nxt_ba = ba_ff;
    nxt_addr = addr_ff;
    nxt_err = 1'b0;
    nxt_pd_act = pd_act_ff;
    nxt_dll_bad = dll_bad_ff;
    nxt_dll_req = dll_req_ff & ~dll_reset_done;
    m_ld = 1'b0;
    m_val = '0;
    l_ld = 1'b0;
    l_val = '0;
    h_ld = 1'b0;
    rearm = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (acc) begin
          case (cmd_op)
            UC_ACT: begin
              if (open_ff[cmd_bank]) begin
                nxt_err = 1'b1;
              end else begin
                nxt_open[cmd_bank] = 1'b1;
                nxt_rcw = PIN_ACT;
                nxt_ba = cmd_bank;
                nxt_addr = cmd_addr;
                m_ld = 1'b1;
                m_val = RCD_CYC;
                nxt_state = ST_WAIT;
              end
            end
            UC_RD, UC_WR: begin
              if (!open_ff[cmd_bank] || (cmd_op == UC_RD && !l_if.idle)) begin
                nxt_err = 1'b1;
              end else begin
                nxt_rcw = (cmd_op == UC_RD) ? PIN_RD : PIN_WR;
                nxt_ba = cmd_bank;
                nxt_addr = cmd_addr;
                if (ap) begin
                  nxt_open[cmd_bank] = 1'b0;
                end
                // burst ends before clock enable may fall
                m_ld = 1'b1;
                m_val = ((cmd_op == UC_RD) ? RD_DONE_CYC : WR_DONE_CYC)
                  + (ap ? RP_CYC : '0);
                nxt_state = ST_WAIT;
              end
            end
            UC_PRE, UC_PREA: begin
              nxt_rcw = PIN_PRE;
              nxt_ba = cmd_bank;
              nxt_addr[ADDR_BIT_TEN] = (cmd_op == UC_PREA);
              if (cmd_op == UC_PREA) begin
                nxt_open = '0;
              end else begin
                nxt_open[cmd_bank] = 1'b0;
              end
              m_ld = 1'b1;
              m_val = (cmd_op == UC_PREA) ? RPA_CYC : RP_CYC;
              nxt_state = ST_WAIT;
            end
            UC_SR_IN: begin
              if (|open_ff) begin
                nxt_err = 1'b1;
              end else begin
                m_ld = 1'b1;
                m_val = ODT_OFF_CYC;
                nxt_state = ST_ODT_OFF;
              end
            end
            UC_PD_IN: begin
              // clock enable kept high in read lockout
              if (!l_if.idle) begin
                nxt_err = 1'b1;
              end else begin
                nxt_cke = 1'b0;
                nxt_pd_act = |open_ff;
                nxt_dll_bad = ~dll_locked;
                h_ld = 1'b1;
                nxt_state = ST_PD;
              end
            end
            default: nxt_err = 1'b1;
          endcase
        end else if (ref_due) begin
          if (|open_ff) begin
            nxt_rcw = PIN_PRE;
            nxt_addr[ADDR_BIT_TEN] = 1'b1;
            nxt_open = '0;
            m_ld = 1'b1;
            m_val = RPA_CYC;
            nxt_state = ST_REF_PRE;
          end else begin
            nxt_rcw = PIN_REF;
            rearm = 1'b1;
            m_ld = 1'b1;
            m_val = RFC_CYC;
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_REF_PRE: begin
        if (m_if.idle) begin
          nxt_rcw = PIN_REF;
          rearm = 1'b1;
          m_ld = 1'b1;
          m_val = RFC_CYC;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (m_if.idle) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ODT_OFF: begin
        if (m_if.idle) begin
          nxt_rcw = PIN_REF;
          nxt_cke = 1'b0;
          h_ld = 1'b1;
          nxt_state = ST_SR;
        end
      end
      ST_SR: begin
        rearm = 1'b1;
        if (acc && cmd_op == UC_SR_OUT) begin
          // both exit timers start at this edge
          nxt_cke = 1'b1;
          h_ld = 1'b1;
          m_ld = 1'b1;
          m_val = XSNR_CYC;
          l_ld = 1'b1;
          l_val = XSRD_CYC;
          nxt_state = ST_WAIT;
        end else if (acc) begin
          nxt_err = 1'b1;
        end
      end
      ST_PD: begin
        // exit with no-op, also forced by refresh
        if ((acc && cmd_op == UC_PD_OUT) ||
            (!acc && ref_due && h_if.idle)) begin
          nxt_cke = 1'b1;
          h_ld = 1'b1;
          m_ld = 1'b1;
          m_val = XP_CYC;
          l_ld = pd_act_ff;
          l_val = slow_exit_sel ? XARDS_CYC : XARD_CYC;
          nxt_dll_req = dll_bad_ff | nxt_dll_req;
          nxt_state = ST_WAIT;
        end else if (acc) begin
          nxt_err = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (rearm) begin
      nxt_refi = hot_temp ? REFI_HOT_CYC : REFI_CYC;
    end else if (refi_ff != '0) begin
      nxt_refi = refi_ff - TMR_W'(1);
    end else begin
      nxt_refi = refi_ff;
    end
    nxt_odt = odt_request & l_if.idle & ~l_ld &
      (nxt_state != ST_ODT_OFF) & (nxt_state != ST_SR);
    acted = m_ld | h_ld | nxt_err;
    // clock enable hold before next change
    nxt_ready = ~acted & ~(ref_due & state_ff == ST_IDLE) & h_if.idle &
      ((state_ff == ST_IDLE && m_if.idle) ||
       state_ff == ST_SR || state_ff == ST_PD);
  end

  assign m_if.load = m_ld;
  assign m_if.value = m_val;
  assign l_if.load = l_ld;
  assign l_if.value = l_val;
  assign h_if.load = h_ld;
  assign h_if.value = CKE_HOLD_CYC;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      open_ff <= '0;
      refi_ff <= REFI_CYC;
      cke_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      rcw_ff <= PIN_NOP;
      ba_ff <= '0;
      addr_ff <= '0;
      odt_ff <= 1'b0;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      pd_act_ff <= 1'b0;
      dll_bad_ff <= 1'b0;
      dll_req_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      open_ff <= nxt_open;
      refi_ff <= nxt_refi;
      cke_ff <= nxt_cke;
      cs_n_ff <= nxt_cs_n;
      rcw_ff <= nxt_rcw;
      ba_ff <= nxt_ba;
      addr_ff <= nxt_addr;
      odt_ff <= nxt_odt;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      pd_act_ff <= nxt_pd_act;
      dll_bad_ff <= nxt_dll_bad;
      dll_req_ff <= nxt_dll_req;
    end
  end

  assign cmd_ready = ready_ff;
  assign cmd_err = err_ff;
  assign cke = cke_ff;
  assign cs_n = cs_n_ff;
  assign ras_n = rcw_ff[2];
  assign cas_n = rcw_ff[1];
  assign we_n = rcw_ff[0];
  assign ba = ba_ff;
  assign addr = addr_ff;
  assign termination_control = odt_ff;
  assign dll_reset_req = dll_req_ff;
  assign in_self_refresh = (state_ff == ST_SR);
  assign in_power_down = (state_ff == ST_PD);
endmodule : ddr_lp_ctrl
`default_nettype wire

// ==== dv/ddr_lp_ctrl_properties.sv ====
`default_nettype none
module ddr_lp_ctrl_properties
  import ddr_lp_pkg::*;
#(
  parameter int BANK_W = 3,
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire ddr_lp_pkg::user_cmd_t cmd_op,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic cmd_ready,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic termination_control,
  input wire logic in_self_refresh
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack covers one command wait that can delay a due refresh
  localparam int REF_GAP_MAX = 850;
  logic [2:0] pins;
  logic quiet;
  logic is_ref;
  logic is_pre;
  logic xs_win;
  logic cke_ff;
  logic sr_ff;
  logic [7:0] xs_ff;
  logic [7:0] nxt_xs;
  logic [10:0] gap_ff;
  logic [10:0] nxt_gap;
  assign pins = {ras_n, cas_n, we_n};
  assign quiet = cs_n || pins == PIN_NOP;
  assign is_ref = !cs_n && pins == PIN_REF;
  assign is_pre = !cs_n && pins == PIN_PRE;
  assign xs_win = xs_ff != 8'h00 && xs_ff <= 8'hC6;
  // ==========================================================
  // Cycles since self-refresh exit and since the last refresh
  always_comb begin
    nxt_xs = xs_ff;
    if (cke && !cke_ff && (sr_ff || in_self_refresh)) begin
      nxt_xs = 8'h01;
    end else if (xs_ff != 8'h00 && xs_ff != 8'hFF) begin
      nxt_xs = xs_ff + 8'h01;
    end
    nxt_gap = (is_ref || in_self_refresh) ? 11'h000 : gap_ff + 11'h001;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cke_ff <= 1'b1;
      sr_ff <= 1'b0;
      xs_ff <= 8'h00;
      gap_ff <= 11'h000;
    end else begin
      cke_ff <= cke;
      sr_ff <= in_self_refresh;
      xs_ff <= nxt_xs;
      gap_ff <= nxt_gap;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_pre_taken;
    cmd_valid && cmd_ready && cmd_op == UC_PRE;
  endsequence
  sequence s_quiet_run;
    quiet [*8] ##1 quiet [*4];
  endsequence
  a_cke_hold: assert property (
    $changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable changed within three edges");
  a_pre_bank_sel: assert property (
    s_pre_taken |=> is_pre && !addr[ADDR_BIT_TEN] && ba == $past(cmd_bank))
    else $error("single-bank precharge pins wrong");
  a_pre_all_sel: assert property (
    cmd_valid && cmd_ready && cmd_op == UC_PREA |=> is_pre && addr[10])
    else $error("all-bank precharge pins wrong");
  a_pre_wait: assert property (
    is_pre |=> quiet)
    else $error("command too soon after precharge");
  a_ref_busy: assert property (
    is_ref && cke |=> s_quiet_run)
    else $error("command inside refresh cycle time");
  a_ref_interval: assert property (
    gap_ff <= REF_GAP_MAX)
    else $error("refresh interval exceeded");
  a_cke_fall_cmd: assert property (
    $fell(cke) |-> quiet || is_ref)
    else $error("clock enable fell with a wrong command");
  a_cke_rise_cmd: assert property (
    $rose(cke) |-> quiet)
    else $error("clock enable rose with a wrong command");
  a_sr_entry: assert property (
    $rose(in_self_refresh) |-> is_ref && !cke)
    else $error("self refresh without refresh and low enable");
  a_xs_quiet: assert property (
    xs_ff inside {[8'h01:8'h0C]} |-> quiet && cke)
    else $error("command or low enable in exit time");
  a_xs_no_read: assert property (
    xs_win |-> !(!cs_n && pins == PIN_RD))
    else $error("read before read exit time");
  a_odt_sr_off: assert property (
    in_self_refresh || xs_win |-> !termination_control)
    else $error("termination on around self refresh");
endmodule : ddr_lp_ctrl_properties
`default_nettype wire

// ==== dv/ddr_dev_model.sv ====
`default_nettype none
module ddr_dev_model
  import ddr_lp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  output logic [7:0] open_ff,
  output logic pd_act_ff,
  output logic [15:0] ref_cnt_ff,
  output logic [15:0] viol_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cke_ff;
  logic [9:0] busy_ff;
  logic [2:0] pins;
  logic sel;
  logic bad;
  assign pins = {ras_n, cas_n, we_n};
  assign sel = !cs_n && pins != PIN_NOP;
  // ==========================================================
  // Faults of the controller
  // Bank, refresh and exit misuse
  always_comb begin
    bad = !cke_ff && cke && sel;
    if (cke_ff && sel) begin
      bad = busy_ff != 10'h000 || (pins == PIN_ACT && open_ff[ba]) ||
        ((pins == PIN_RD || pins == PIN_WR) && !open_ff[ba]) ||
        (pins == PIN_REF && open_ff != 8'h00);
    end
  end
  always_ff @(posedge clk) begin
    cke_ff <= cke;
    if (reset) begin
      open_ff <= 8'h00;
      pd_act_ff <= 1'b0;
      ref_cnt_ff <= 16'h0000;
      viol_ff <= 16'h0000;
      busy_ff <= 10'h000;
    end else begin
      viol_ff <= viol_ff + 16'(bad);
      if (busy_ff != 10'h000) begin
        busy_ff <= busy_ff - 10'h001;
      end
      if (cke_ff && sel) begin
        case (pins)
          PIN_ACT: open_ff[ba] <= 1'b1;
          PIN_PRE: begin
            if (addr[ADDR_BIT_TEN]) begin
              open_ff <= 8'h00;
            end else begin
              open_ff[ba] <= 1'b0;
            end
          end
          PIN_RD, PIN_WR: begin
            if (addr[ADDR_BIT_TEN]) begin
              open_ff[ba] <= 1'b0;
            end
          end
          // Refresh cycle; self refresh runs inside
          PIN_REF: begin
            busy_ff <= RFC_CYC - 10'h001;
            ref_cnt_ff <= ref_cnt_ff + 16'h0001;
          end
          default: ;
        endcase
      end
      if (cke_ff && !cke && !sel) begin
        pd_act_ff <= |open_ff;
      end
    end
  end
endmodule : ddr_dev_model
`default_nettype wire

// ==== dv/ddr_lp_ctrl_tb_top.sv ====
`default_nettype none
module ddr_lp_ctrl_tb_top
  import ddr_lp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cmd_valid, slow_exit_sel, odt_request;
  logic dll_reset_done, hot_temp_pin, dll_locked_pin;
  user_cmd_t cmd_op;
  logic [2:0] cmd_bank, ba;
  logic [13:0] cmd_addr, addr;
  logic cmd_ready, cmd_err, cke, cs_n, ras_n, cas_n, we_n;
  logic termination_control, dll_reset_req, in_self_refresh, in_power_down;
  logic [7:0] open_banks;
  logic pd_act;
  logic [15:0] ref_cnt, viol;
  int error_cnt = 0;
  int compares = 0;
  ddr_lp_ctrl dut_u (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .slow_exit_sel(slow_exit_sel), .odt_request(odt_request),
    .dll_reset_done(dll_reset_done), .hot_temp_pin(hot_temp_pin),
    .dll_locked_pin(dll_locked_pin), .cmd_ready(cmd_ready),
    .cmd_err(cmd_err), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .termination_control(termination_control),
    .dll_reset_req(dll_reset_req), .in_self_refresh(in_self_refresh),
    .in_power_down(in_power_down));
  ddr_dev_model dev_u (.clk(clk), .reset(reset), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .open_ff(open_banks), .pd_act_ff(pd_act), .ref_cnt_ff(ref_cnt),
    .viol_ff(viol));
  always #5 clk = ~clk;
  // ==========================================================
  // Tasks
  task automatic test_done();
    $display("Compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Holds the request until a ready edge takes it, then checks refusal
  task automatic req(input user_cmd_t op, input logic [2:0] b,
    input logic [13:0] a, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    cmd_op <= op;
    cmd_bank <= b;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      test_done();
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    check("cmd_err", 32'(cmd_err), 32'(err));
  endtask : req
  // Measures the gap between two refresh commands against span
  task automatic ref_gap(input int span);
    logic [15:0] r;
    int n;
    r = ref_cnt;
    n = 0;
    while (ref_cnt === r && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      test_done();
    end
    r = ref_cnt;
    cyc(span - 20);
    check("early refresh", 32'(ref_cnt - r), 32'h0);
    cyc(40);
    check("late refresh", 32'(ref_cnt - r), 32'h1);
  endtask : ref_gap
  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = UC_ACT;
    cmd_bank = 3'h0;
    cmd_addr = 14'h0000;
    slow_exit_sel = 1'b0;
    odt_request = 1'b0;
    dll_reset_done = 1'b0;
    hot_temp_pin = 1'b0;
    dll_locked_pin = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    req(UC_ACT, 3'h2, 14'h0123, 1'b0);
    req(UC_ACT, 3'h5, 14'h0040, 1'b0);
    req(UC_RD, 3'h3, 14'h0000, 1'b1);
    req(UC_ACT, 3'h2, 14'h0123, 1'b1);
    req(UC_PRE, 3'h2, 14'h0000, 1'b0);
    cyc(2);
    check("open banks", 32'(open_banks), 32'h20);
    req(UC_RD, 3'h5, 14'h0400, 1'b0);
    cyc(2);
    check("open banks", 32'(open_banks), 32'h0);
    req(UC_ACT, 3'h1, 14'h0200, 1'b0);
    req(UC_PD_IN, 3'h0, 14'h0000, 1'b0);
    cyc(2);
    check("in_power_down", 32'(in_power_down), 32'h1);
    check("active power-down", 32'(pd_act), 32'h1);
    @(posedge clk);
    slow_exit_sel <= 1'b1;
    req(UC_PD_OUT, 3'h0, 14'h0000, 1'b0);
    // Slow exit keeps reads locked out past the non-read exit time
    req(UC_RD, 3'h1, 14'h0008, 1'b1);
    cyc(4);
    req(UC_RD, 3'h1, 14'h0008, 1'b0);
    check("in_power_down", 32'(in_power_down), 32'h0);
    req(UC_PREA, 3'h6, 14'h0400, 1'b0);
    cyc(2);
    check("open banks", 32'(open_banks), 32'h0);
    @(posedge clk);
    dll_locked_pin <= 1'b0;
    cyc(4);
    req(UC_PD_IN, 3'h0, 14'h0000, 1'b0);
    cyc(2);
    check("active power-down", 32'(pd_act), 32'h0);
    req(UC_PD_OUT, 3'h0, 14'h0000, 1'b0);
    cyc(2);
    check("dll_reset_req", 32'(dll_reset_req), 32'h1);
    @(posedge clk);
    dll_reset_done <= 1'b1;
    dll_locked_pin <= 1'b1;
    @(posedge clk);
    dll_reset_done <= 1'b0;
    cyc(2);
    check("dll_reset_req", 32'(dll_reset_req), 32'h0);
    @(posedge clk);
    odt_request <= 1'b1;
    req(UC_ACT, 3'h0, 14'h0010, 1'b0);
    req(UC_SR_IN, 3'h0, 14'h0000, 1'b1);
    req(UC_PREA, 3'h0, 14'h0400, 1'b0);
    req(UC_SR_IN, 3'h0, 14'h0000, 1'b0);
    cyc(10);
    check("in_self_refresh", 32'(in_self_refresh), 32'h1);
    check("cke", 32'(cke), 32'h0);
    check("termination", 32'(termination_control), 32'h0);
    req(UC_SR_OUT, 3'h0, 14'h0000, 1'b0);
    req(UC_ACT, 3'h4, 14'h0020, 1'b0);
    req(UC_PD_IN, 3'h0, 14'h0000, 1'b1);
    req(UC_RD, 3'h4, 14'h0000, 1'b1);
    cyc(200);
    req(UC_RD, 3'h4, 14'h0000, 1'b0);
    ref_gap(781);
    @(posedge clk);
    hot_temp_pin <= 1'b1;
    // The interval armed before the pin rose still runs out first
    ref_gap(390);
    ref_gap(390);
    check("device faults", 32'(viol), 32'h0);
    test_done();
  end
endmodule : ddr_lp_ctrl_tb_top
bind ddr_lp_ctrl ddr_lp_ctrl_properties #(.BANK_W(BANK_W),
  .ADDR_W(ADDR_W)) chk_u (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bank(cmd_bank),
  .cmd_ready(cmd_ready), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
  .termination_control(termination_control),
  .in_self_refresh(in_self_refresh));
`default_nettype wire
